// [hdl/bfs_breaker_failure_monitor.v]
/*
  Breaker failure monitor: trip triggers start a supervision timer; if the
  breaker is not seen to open in time it raises a backup trip and a
  latched lock. Registers over AXI4-Lite.
  Assumes trigger sources and current magnitude come from logic on aclk;
  the breaker position input is an asynchronous pin.
*/
// Added by the designer: the register offsets and register access over AXI4-Lite.
// Operation
// - Offer current, position and combined supervision schemes.
// - Start the supervision timer when an active trigger arrives.
// - Current scheme fails if current stays above threshold until expiry.
// - Position scheme fails if position never reports open before expiry.
// - Combined scheme fails only if current high and position not open.
// - Timer keeps running even when the trigger drops.
// - Timer expiry without opening asserts the breaker failure trip.
// - Stop the timer as soon as opening is detected per scheme.
// - Go to rejected when opening is detected while triggers remain.
// - Stay rejected, no restart, until the trigger drops.
// - Return from rejected to standby once all triggers are gone.
// - Assert the lock in the same cycle as the failure trip.
// - Lock stays latched until an operator acknowledgement clears it.
// - External-trip mode: assigned external trips start the block.
// - Current-trip mode: assigned current trips start the block.
// - No-assignment mode: only the extra trigger inputs start it.
// - Three extra trigger inputs start supervision regardless of assignment.
// - Threshold and time come from the active one of four sets.
// - Failure trip routable to output relay or communication path.
`timescale 1ns/10ps
`include "bfs_consts.vh"

module bfs_breaker_failure_monitor #(
  parameter CUR_W = 16,
  parameter TIME_W = 16,
  parameter TICK_CYCLES = `BFS_TICK_NS / `BFS_CLK_NS
) (
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // AXI4-Lite write address
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  // AXI4-Lite write data
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  // AXI4-Lite write response
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // AXI4-Lite read address
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  // AXI4-Lite read data
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // Trigger sources
  input wire external_trip_assigned,
  input wire current_trip_assigned,
  input wire extra_trigger_input_a,
  input wire extra_trigger_input_b,
  input wire extra_trigger_input_c,
  // Breaker measurement and position
  input wire [CUR_W-1:0] measured_current,
  input wire breaker_open_pin,
  // Front panel acknowledgement
  input wire panel_ack,
  // Outputs
  output reg failure_trip_q,
  output reg lock_q,
  output wire backup_trip_relay,
  output wire backup_trip_comm,
  output wire [1:0] monitor_state
);

  localparam ST_STANDBY = 2'h0;
  localparam ST_RUNNING = 2'h1;
  localparam ST_REJECTED = 2'h2;
  localparam ST_TRIPPED = 2'h3;
  localparam integer TICK_M1 = TICK_CYCLES - 1;
  localparam [14:0] TICK_LAST = TICK_M1[14:0];
  // Opening decision per scheme
  function opening_seen;
    input [1:0] scheme;
    input cur_low;
    input pos_open;
    begin
      case (scheme)
        `BFS_SCH_CURRENT: opening_seen = cur_low;
        `BFS_SCH_POSITION: opening_seen = pos_open;
        `BFS_SCH_COMBINED: opening_seen = cur_low | pos_open;
        default: opening_seen = cur_low;
      endcase
    end
  endfunction
  // Word address decode of parameter sets
  function [2:0] set_slot;
    input [7:0] addr;
    begin
      set_slot = addr[5:3] - 3'h2;
    end
  endfunction
  function in_sets;
    input [7:0] addr;
    begin
      in_sets = (addr >= `BFS_OFS_SET0) && (addr < `BFS_OFS_SET_END);
    end
  endfunction
  reg [7:0] ctrl_q;
  reg [CUR_W-1:0] thresh_q [0:3];
  reg [TIME_W-1:0] time_q [0:3];
  reg [1:0] state_q;
  reg [1:0] state_d;
  reg [TIME_W-1:0] elapsed_q;
  reg [14:0] tick_cnt_q;
  reg tick_q;
  reg pos_meta_q;
  reg pos_sync_q;
  reg aw_held_q;
  reg w_held_q;
  reg [7:0] aw_addr_q;
  reg [31:0] w_data_q;
  reg [3:0] w_strb_q;
  reg ack_wr_q;
  integer i;
  wire [1:0] scheme = ctrl_q[`BFS_CTRL_SCHEME_LSB +: 2];
  wire [1:0] trig_mode = ctrl_q[`BFS_CTRL_TRIG_LSB +: 2];
  wire [1:0] set_sel = ctrl_q[`BFS_CTRL_SET_LSB +: 2];
  wire [CUR_W-1:0] act_thresh = thresh_q[set_sel];
  wire [TIME_W-1:0] act_time = time_q[set_sel];
  wire cur_low = measured_current < act_thresh;
  wire opening = opening_seen(scheme, cur_low, pos_sync_q);
  wire expired = elapsed_q >= act_time;
  reg mode_src;
  wire trigger;

  // Trigger mode selection
  always @* begin
    case (trig_mode)
      `BFS_TRG_EXTERNAL: mode_src = external_trip_assigned;
      `BFS_TRG_CURRENT: mode_src = current_trip_assigned;
      `BFS_TRG_NONE: mode_src = 1'b0;
      default: mode_src = 1'b0;
    endcase
  end

  assign trigger = mode_src | extra_trigger_input_a |
    extra_trigger_input_b | extra_trigger_input_c;

  // Position pin synchroniser
  always @(posedge aclk) begin
    if (!aresetn) begin
      pos_meta_q <= 1'b0;
      pos_sync_q <= 1'b0;
    end else begin
      pos_meta_q <= breaker_open_pin;
      pos_sync_q <= pos_meta_q;
    end
  end
  // Supervision time unit enable
  always @(posedge aclk) begin
    if (!aresetn || state_q != ST_RUNNING) begin
      tick_cnt_q <= 15'h0000;
      tick_q <= 1'b0;
    end else if (tick_cnt_q == TICK_LAST) begin
      tick_cnt_q <= 15'h0000;
      tick_q <= 1'b1;
    end else begin
      tick_cnt_q <= tick_cnt_q + 15'h0001;
      tick_q <= 1'b0;
    end
  end
  // Supervision state machine
  always @* begin
    state_d = state_q;
    case (state_q)
      ST_STANDBY: begin
        if (trigger) begin
          state_d = ST_RUNNING;
        end
      end
      ST_RUNNING: begin
        if (opening) begin
          if (trigger) begin
            state_d = ST_REJECTED;
          end else begin
            state_d = ST_STANDBY;
          end
        end else if (expired) begin
          state_d = ST_TRIPPED;
        end
      end
      ST_REJECTED: begin
        if (!trigger) begin
          state_d = ST_STANDBY;
        end
      end
      ST_TRIPPED: begin
        if (!trigger) begin
          state_d = ST_STANDBY;
        end
      end
      default: state_d = ST_STANDBY;
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= ST_STANDBY;
      elapsed_q <= {TIME_W{1'b0}};
      failure_trip_q <= 1'b0;
    end else begin
      state_q <= state_d;
      if (state_q != ST_RUNNING) begin
        elapsed_q <= {TIME_W{1'b0}};
      end else if (tick_q) begin
        elapsed_q <= elapsed_q + 1'b1;
      end
      failure_trip_q <= (state_d == ST_TRIPPED);
    end
  end

  // Lock latch, set wins over acknowledgement
  wire lock_clear = panel_ack | ack_wr_q;
  always @(posedge aclk) begin
    if (!aresetn) begin
      lock_q <= 1'b0;
    end else if (state_d == ST_TRIPPED && state_q == ST_RUNNING) begin
      lock_q <= 1'b1;
    end else if (lock_clear) begin
      lock_q <= 1'b0;
    end
  end

  assign backup_trip_relay = failure_trip_q & ctrl_q[`BFS_CTRL_RELAY_BIT];
  assign backup_trip_comm = failure_trip_q & ctrl_q[`BFS_CTRL_COMM_BIT];
  assign monitor_state = state_q;

  // Write channel capture
  assign s_axi_awready = !aw_held_q && !s_axi_bvalid;
  assign s_axi_wready = !w_held_q && !s_axi_bvalid;

  wire wr_go = aw_held_q && w_held_q && !s_axi_bvalid;
  wire wr_set = in_sets(aw_addr_q);
  wire [2:0] wr_slot = set_slot(aw_addr_q);
  wire wr_ok = (aw_addr_q == `BFS_OFS_CTRL) || (aw_addr_q == `BFS_OFS_STAT) ||
    (aw_addr_q == `BFS_OFS_ACK) || (wr_set && aw_addr_q[1:0] == 2'h0);

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `BFS_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_held_q <= 1'b0;
        w_held_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? `BFS_RESP_OKAY : `BFS_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Register writes
  always @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= `BFS_CTRL_RESET;
      ack_wr_q <= 1'b0;
      for (i = 0; i < 4; i = i + 1) begin
        thresh_q[i] <= `BFS_THRESH_RESET;
        time_q[i] <= `BFS_TIME_RESET;
      end
    end else begin
      ack_wr_q <= 1'b0;
      if (wr_go && wr_ok) begin
        if (aw_addr_q == `BFS_OFS_CTRL && w_strb_q[0]) begin
          ctrl_q <= w_data_q[7:0];
        end
        if (aw_addr_q == `BFS_OFS_ACK && w_strb_q[0]) begin
          ack_wr_q <= w_data_q[`BFS_ACK_BIT];
        end
        if (wr_set && !aw_addr_q[2]) begin
          if (w_strb_q[0]) begin
            thresh_q[wr_slot[1:0]][7:0] <= w_data_q[7:0];
          end
          if (w_strb_q[1]) begin
            thresh_q[wr_slot[1:0]][CUR_W-1:8] <= w_data_q[CUR_W-1:8];
          end
        end
        if (wr_set && aw_addr_q[2]) begin
          if (w_strb_q[0]) begin
            time_q[wr_slot[1:0]][7:0] <= w_data_q[7:0];
          end
          if (w_strb_q[1]) begin
            time_q[wr_slot[1:0]][TIME_W-1:8] <= w_data_q[TIME_W-1:8];
          end
        end
      end
    end
  end

  // Read channel
  assign s_axi_arready = !s_axi_rvalid;

  reg [31:0] rd_word;
  reg rd_ok;
  wire [2:0] rd_slot = set_slot(s_axi_araddr);

  always @* begin
    rd_word = 32'h0000_0000;
    rd_ok = 1'b1;
    if (s_axi_araddr == `BFS_OFS_CTRL) begin
      rd_word[7:0] = ctrl_q;
    end else if (s_axi_araddr == `BFS_OFS_STAT) begin
      rd_word[`BFS_STAT_STATE_LSB +: 2] = state_q;
      rd_word[`BFS_STAT_TRIP_BIT] = failure_trip_q;
      rd_word[`BFS_STAT_LOCK_BIT] = lock_q;
      rd_word[`BFS_STAT_OPEN_BIT] = opening;
      rd_word[`BFS_STAT_TRIG_BIT] = trigger;
    end else if (s_axi_araddr == `BFS_OFS_ACK) begin
      rd_word = 32'h0000_0000;
    end else if (in_sets(s_axi_araddr) && s_axi_araddr[1:0] == 2'h0) begin
      if (s_axi_araddr[2]) begin
        rd_word[TIME_W-1:0] = time_q[rd_slot[1:0]];
      end else begin
        rd_word[CUR_W-1:0] = thresh_q[rd_slot[1:0]];
      end
    end else begin
      rd_ok = 1'b0;
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `BFS_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word;
      s_axi_rresp <= rd_ok ? `BFS_RESP_OKAY : `BFS_RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule

// [hdl/bfs_consts.vh]
/*
  Constants of the breaker failure supervision block: register offsets,
  field positions, reset values, codes and timing figures.
  Assumes inclusion by bare name from the design file.
*/
`ifndef BFS_CONSTS_VH
`define BFS_CONSTS_VH

// Register byte offsets
`define BFS_OFS_CTRL 8'h00
`define BFS_OFS_STAT 8'h04
`define BFS_OFS_ACK 8'h08
`define BFS_OFS_SET0 8'h10
`define BFS_SET_STRIDE 8'h08
`define BFS_OFS_SET_END 8'h30

// Control field positions
`define BFS_CTRL_SCHEME_LSB 0
`define BFS_CTRL_TRIG_LSB 2
`define BFS_CTRL_SET_LSB 4
`define BFS_CTRL_RELAY_BIT 6
`define BFS_CTRL_COMM_BIT 7
`define BFS_CTRL_RESET 8'h49

// Status field positions
`define BFS_STAT_STATE_LSB 0
`define BFS_STAT_TRIP_BIT 2
`define BFS_STAT_LOCK_BIT 3
`define BFS_STAT_OPEN_BIT 4
`define BFS_STAT_TRIG_BIT 5
`define BFS_ACK_BIT 0

// Scheme codes
`define BFS_SCH_CURRENT 2'h0
`define BFS_SCH_POSITION 2'h1
`define BFS_SCH_COMBINED 2'h2

// Trigger mode codes
`define BFS_TRG_NONE 2'h0
`define BFS_TRG_EXTERNAL 2'h1
`define BFS_TRG_CURRENT 2'h2

// Parameter set reset values
`define BFS_THRESH_RESET 16'h0100
`define BFS_TIME_RESET 16'h0096

// Timing: supervision time unit and clock period
`define BFS_TICK_NS 1000000
`define BFS_CLK_NS 50

// Bus answers
`define BFS_RESP_OKAY 2'h0
`define BFS_RESP_SLVERR 2'h2

`endif

// [test/bfs_asserts.sv]
/*
  Checker for the breaker failure monitor ports.
  Assumes binding to the monitor top module, one clock aclk.
*/
`timescale 1ns/10ps
module bfs_asserts (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Inputs watched
  input wire logic external_trip_assigned,
  input wire logic current_trip_assigned,
  input wire logic extra_trigger_input_a,
  input wire logic extra_trigger_input_b,
  input wire logic extra_trigger_input_c,
  input wire logic panel_ack,
  input wire logic s_axi_wvalid,
  // Outputs watched
  input wire logic failure_trip_q,
  input wire logic lock_q,
  input wire logic backup_trip_relay,
  input wire logic backup_trip_comm,
  input wire logic [1:0] monitor_state
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic extra;
  logic any_trig;
  assign extra = extra_trigger_input_a | extra_trigger_input_b | extra_trigger_input_c;
  assign any_trig = extra | external_trip_assigned | current_trip_assigned;
  a_lock_with_trip: assert property ($rose(failure_trip_q) |-> lock_q)
    else $error("lock missing at trip");
  a_trip_state: assert property (failure_trip_q == (monitor_state == 2'h3))
    else $error("trip and state disagree");
  a_route_gated: assert property ((backup_trip_relay | backup_trip_comm) |-> failure_trip_q)
    else $error("route without trip");
  a_trip_from_run: assert property ($rose(failure_trip_q) |-> $past(monitor_state) == 2'h1)
    else $error("trip not from running");
  a_lock_stays: assert property ($fell(lock_q) |-> $past(panel_ack) || $past(panel_ack, 2)
    || $past(s_axi_wvalid) || $past(s_axi_wvalid, 2) || $past(s_axi_wvalid, 3))
    else $error("lock cleared without ack");
  a_reject_holds: assert property (monitor_state == 2'h2 && extra |=> monitor_state == 2'h2)
    else $error("rejected left with trigger");
  a_reject_exit: assert property (monitor_state == 2'h2 && !any_trig |=> monitor_state == 2'h0)
    else $error("rejected not left");
  a_extra_starts: assert property (monitor_state == 2'h0 && extra |=> monitor_state == 2'h1)
    else $error("extra trigger did not start");
  a_trip_drop: assert property ($fell(failure_trip_q) |-> monitor_state == 2'h0)
    else $error("trip dropped outside standby");
endmodule

bind bfs_breaker_failure_monitor bfs_asserts u_asserts (.aclk, .aresetn,
  .external_trip_assigned, .current_trip_assigned, .extra_trigger_input_a,
  .extra_trigger_input_b, .extra_trigger_input_c, .panel_ack, .s_axi_wvalid,
  .failure_trip_q, .lock_q, .backup_trip_relay, .backup_trip_comm, .monitor_state);

// [test/bfs_breaker_model.sv]
/*
  Monitored breaker: opens a set number of cycles after a trip command.
  Assumes zero delay means stuck; indicators may be told to lie.
*/
`timescale 1ns/10ps
module bfs_breaker_model (
  // Clock
  input wire logic aclk,
  // Command and behaviour
  input wire logic trip_cmd,
  input wire logic [7:0] open_delay,
  input wire logic pos_truthful,
  input wire logic cur_truthful,
  // Indicators
  output logic breaker_open_pin,
  output logic [15:0] measured_current
);
  logic [7:0] cnt_q = 8'h00;
  logic open_q = 1'b0;
  always @(posedge aclk) begin
    if (!trip_cmd) begin
      cnt_q <= 8'h00;
      open_q <= 1'b0;
    end else if (open_delay != 8'h00 && cnt_q == open_delay) begin
      open_q <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 8'h01;
    end
  end
  assign breaker_open_pin = open_q & pos_truthful;
  assign measured_current = (open_q & cur_truthful) ? 16'h0010 : 16'h0400;
endmodule

// [test/bfs_breaker_failure_monitor_tb_top.sv]
/*
  Testbench for the breaker failure monitor.
  Assumes the breaker model and the bound checker are compiled before.
*/
`timescale 1ns/10ps
module bfs_breaker_failure_monitor_tb_top;
  logic aclk = 0, aresetn = 0;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0, dly = 8'h08;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, failure_trip_q, lock_q, backup_trip_relay, backup_trip_comm;
  logic [1:0] s_axi_bresp, s_axi_rresp, monitor_state, r;
  logic external_trip_assigned = 0, current_trip_assigned = 0, panel_ack = 0;
  logic [2:0] xt = 0;
  logic [15:0] measured_current;
  logic breaker_open_pin, pos_ok = 1, cur_ok = 1, exp, seen;
  int n_errors = 0, compares = 0;
  always #25 aclk = ~aclk;
  bfs_breaker_failure_monitor #(.TICK_CYCLES(4)) dut (.aclk, .aresetn, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .external_trip_assigned, .current_trip_assigned,
    .extra_trigger_input_a(xt[0]), .extra_trigger_input_b(xt[1]),
    .extra_trigger_input_c(xt[2]), .measured_current, .breaker_open_pin, .panel_ack,
    .failure_trip_q, .lock_q, .backup_trip_relay, .backup_trip_comm, .monitor_state);
  bfs_breaker_model model (.aclk, .trip_cmd(external_trip_assigned | current_trip_assigned
    | (|xt)), .open_delay(dly), .pos_truthful(pos_ok), .cur_truthful(cur_ok),
    .breaker_open_pin, .measured_current);
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] v);
    logic ta, tw, pa, pw, tb;
    pa = 1;
    pw = 1;
    tb = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    while (pa || pw) begin
      @(negedge aclk);
      ta = s_axi_awready;
      tw = s_axi_wready;
      @(posedge aclk);
      if (pa && ta) begin
        s_axi_awvalid <= 0;
        pa = 0;
      end
      if (pw && tw) begin
        s_axi_wvalid <= 0;
        pw = 0;
      end
    end
    while (!tb) begin
      @(negedge aclk);
      tb = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge aclk);
    end
    s_axi_bready <= 0;
  endtask
  task rd(input logic [7:0] a);
    logic t;
    t = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    while (!t) begin
      @(negedge aclk);
      t = s_axi_arready;
      @(posedge aclk);
    end
    s_axi_arvalid <= 0;
    t = 0;
    while (!t) begin
      @(negedge aclk);
      t = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge aclk);
    end
    s_axi_rready <= 0;
  endtask
  task end_sim;
    if (n_errors == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    repeat (40000) @(posedge aclk);
    n_errors++;
    end_sim;
  end
  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1;
    rd(8'h00);
    chk("ctrl reset", 32'h49, d);
    rd(8'h40);
    chk("unmapped resp", 2'h2, r);
    wr(8'h18, 32'h0200);
    chk("wr resp", 2'h0, r);
    wr(8'h1c, 32'h000a);
    rd(8'h18);
    chk("set1 thresh", 32'h200, d);
    for (int s = 0; s < 3; s++) for (int f = 0; f < 4; f++) begin
      wr(8'h00, (s == 1 ? 32'h50 : 32'hd0) | s);
      exp = (f == 3) || (f == 1 && s == 1) || (f == 2 && s == 0);
      @(posedge aclk);
      dly <= (f == 3) ? 8'h00 : 8'h08;
      pos_ok <= (f != 1);
      cur_ok <= (f != 2);
      xt[s] <= 1;
      seen = 0;
      @(posedge aclk);
      xt[s] <= (f != 3);
      repeat (60) begin
        @(negedge aclk);
        seen = seen | failure_trip_q;
      end
      chk("trip", exp, seen);
      chk("lock", exp, lock_q);
      chk("relay", exp && f != 3, backup_trip_relay);
      chk("comm", exp && f != 3 && s != 1, backup_trip_comm);
      chk("state", f == 3 ? 0 : (exp ? 3 : 2), monitor_state);
      @(posedge aclk);
      xt[s] <= 0;
      repeat (3) @(negedge aclk);
      chk("idle", 0, monitor_state);
      chk("lock held", exp, lock_q);
      if (s == 2) wr(8'h08, 32'h1);
      else begin
        @(posedge aclk);
        panel_ack <= 1;
        @(posedge aclk);
        panel_ack <= 0;
      end
      repeat (3) @(negedge aclk);
      chk("lock clear", 0, lock_q);
    end
    for (int m = 0; m < 3; m++) for (int k = 1; k < 3; k++) begin
      wr(8'h00, 32'h10 | (m << 2));
      @(posedge aclk);
      dly <= 8'h08;
      cur_ok <= 1;
      external_trip_assigned <= (k == 1);
      current_trip_assigned <= (k == 2);
      repeat (20) @(negedge aclk);
      chk("mode start", (m == k) ? 2 : 0, monitor_state);
      @(posedge aclk);
      external_trip_assigned <= 0;
      current_trip_assigned <= 0;
      repeat (3) @(negedge aclk);
    end
    end_sim;
  end
endmodule
